// ==== common/spirq_pkg.sv ====
/*
  spirq_pkg: constants shared by the serial port interrupt routing block.
  assumes a 32-bit avalon-mm word bus; all registers one aligned word each.
*/
`default_nettype none
package spirq_pkg;
  localparam int SPIRQ_NPORTS = 2;
  localparam int SPIRQ_AW = 4;
  localparam int SPIRQ_DW = 32;
  // byte addresses
  localparam logic [SPIRQ_AW-1:0] SPIRQ_OFF_IER0 = 4'h0;
  localparam logic [SPIRQ_AW-1:0] SPIRQ_OFF_MCR0 = 4'h4;
  localparam logic [SPIRQ_AW-1:0] SPIRQ_OFF_IER1 = 4'h8;
  localparam logic [SPIRQ_AW-1:0] SPIRQ_OFF_MCR1 = 4'hC;
  // irq_source_enable_reg fields
  localparam int SPIRQ_IER_RXDATA = 0;
  localparam int SPIRQ_IER_THRE = 1;
  localparam int SPIRQ_IER_RXERR = 2;
  localparam int SPIRQ_IER_MODEM = 3;
  localparam int SPIRQ_IER_W = 4;
  // modem control register fields
  localparam int SPIRQ_MCR_GATE = 3;
  localparam int SPIRQ_MCR_W = 8;
  localparam int SPIRQ_MCR_SLOT_LO = 8;
  localparam int SPIRQ_MCR_W_ALL = 10;
  // slot designation codes
  localparam logic [1:0] SPIRQ_SLOT_FIRST = 2'h0;
  localparam logic [1:0] SPIRQ_SLOT_SECOND = 2'h1;
  localparam logic [1:0] SPIRQ_SLOT_THIRD = 2'h2;
  localparam logic [1:0] SPIRQ_SLOT_FOURTH = 2'h3;
  localparam logic [1:0] SPIRQ_SLOT_RST0 = 2'h0;
  localparam logic [1:0] SPIRQ_SLOT_RST1 = 2'h1;
  localparam logic [SPIRQ_DW-1:0] SPIRQ_RD_UNMAPPED = 32'h0000_0000;
endpackage : spirq_pkg
`default_nettype wire

// ==== rtl/spirq_top.sv ====
/*
  spirq_top: interrupt request outputs of two serial ports, routed onto two
  host lines by slot designation, gated by source enables and modem gate bit.
  assumes uart cores deliver source levels that stay high until serviced.
*/
// Summary of operation
// - both interrupt lines are active high; high means an interrupt is pending
// - second or fourth slot uses line a; first or third uses line b
// - line asserts only with source enabled and modem gate bit set
// - sources: receiver error, rx data, tx holding empty, modem status change
// - line drops after service, after source disable, or on master reset
// - line floats (output enable low) while every port routed to it has its gate bit zero
// - master reset is active high and restores register defaults
`default_nettype none
module spirq_top
  import spirq_pkg::*;
#(
  parameter int NPORTS = spirq_pkg::SPIRQ_NPORTS
) (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [spirq_pkg::SPIRQ_AW-1:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [spirq_pkg::SPIRQ_DW-1:0] avs_writedata,
  input wire logic [3:0] avs_byteenable,
  output logic [spirq_pkg::SPIRQ_DW-1:0] avs_readdata,
  output logic avs_waitrequest,
  input wire logic [1:0] src_rx_error,
  input wire logic [1:0] src_rx_data,
  input wire logic [1:0] src_thr_empty,
  input wire logic [1:0] src_modem_change,
  output logic serial_irq_line_a,
  output logic serial_irq_line_a_oe,
  output logic serial_irq_line_b,
  output logic serial_irq_line_b_oe
);
  import spirq_pkg::*;

  // the routing and register map are laid out for exactly two ports
  if (NPORTS != SPIRQ_NPORTS) begin : g_bad_nports
    $error("spirq_top serves exactly two ports");
  end

  logic [SPIRQ_IER_W-1:0] irq_source_enable_reg [SPIRQ_NPORTS];
  logic [SPIRQ_MCR_W-1:0] mcr_reg [SPIRQ_NPORTS];
  logic [1:0] slot_reg [SPIRQ_NPORTS];
  logic [SPIRQ_NPORTS-1:0] req_reg;
  logic [SPIRQ_NPORTS-1:0] gate;
  logic [SPIRQ_NPORTS-1:0] to_a;
  logic ack_reg;
  logic [SPIRQ_DW-1:0] rdata_next;
  logic a_next;
  logic b_next;
  logic a_oe_next;
  logic b_oe_next;
  logic line_a_reg;
  logic line_b_reg;
  logic line_a_oe_reg;
  logic line_b_oe_reg;

  wire logic access = avs_read | avs_write;
  // one wait state per access keeps read data registered
  assign avs_waitrequest = access & ~ack_reg;

  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_reg <= 1'b0;
    end else begin
      ack_reg <= access & ~ack_reg;
    end
  end

  wire logic wr_take = avs_write & ack_reg & avs_byteenable[0];

  genvar p;
  generate
    for (p = 0; p < SPIRQ_NPORTS; p++) begin : g_port
      localparam logic [SPIRQ_AW-1:0] IER_OFF = (p == 0) ? SPIRQ_OFF_IER0 : SPIRQ_OFF_IER1;
      localparam logic [SPIRQ_AW-1:0] MCR_OFF = (p == 0) ? SPIRQ_OFF_MCR0 : SPIRQ_OFF_MCR1;
      localparam logic [1:0] SLOT_RST = (p == 0) ? SPIRQ_SLOT_RST0 : SPIRQ_SLOT_RST1;
      logic [SPIRQ_IER_W-1:0] pend;

      always_ff @(posedge mclk) begin
        if (reset) begin
          irq_source_enable_reg[p] <= '0;
        end else if (wr_take && avs_address == IER_OFF) begin
          irq_source_enable_reg[p] <= avs_writedata[SPIRQ_IER_W-1:0];
        end
      end

      always_ff @(posedge mclk) begin
        if (reset) begin
          mcr_reg[p] <= '0;
          slot_reg[p] <= SLOT_RST;
        end else if (wr_take && avs_address == MCR_OFF) begin
          mcr_reg[p] <= avs_writedata[SPIRQ_MCR_W-1:0];
          if (avs_byteenable[1]) begin
            slot_reg[p] <= avs_writedata[SPIRQ_MCR_W_ALL-1:SPIRQ_MCR_SLOT_LO];
          end
        end
      end

      always_comb begin
        pend = '0;
        pend[SPIRQ_IER_RXDATA] = src_rx_data[p];
        pend[SPIRQ_IER_THRE] = src_thr_empty[p];
        pend[SPIRQ_IER_RXERR] = src_rx_error[p];
        pend[SPIRQ_IER_MODEM] = src_modem_change[p];
      end

      assign gate[p] = mcr_reg[p][SPIRQ_MCR_GATE];
      // level request: holds while the gate bit is set and any enabled source pends, drops once serviced
      assign req_reg[p] = gate[p] & (|(pend & irq_source_enable_reg[p]));
      assign to_a[p] = (slot_reg[p] == SPIRQ_SLOT_SECOND) ||
                       (slot_reg[p] == SPIRQ_SLOT_FOURTH);
    end
  endgenerate

  always_comb begin
    a_next = 1'b0;
    b_next = 1'b0;
    a_oe_next = 1'b0;
    b_oe_next = 1'b0;
    for (int i = 0; i < SPIRQ_NPORTS; i++) begin
      // a gated-off port leaves its line floating for the other port
      if (to_a[i]) begin
        a_next = a_next | req_reg[i];
        a_oe_next = a_oe_next | gate[i];
      end else begin
        b_next = b_next | req_reg[i];
        b_oe_next = b_oe_next | gate[i];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      line_a_reg <= 1'b0;
      line_b_reg <= 1'b0;
      line_a_oe_reg <= 1'b0;
      line_b_oe_reg <= 1'b0;
    end else begin
      line_a_reg <= a_next;
      line_b_reg <= b_next;
      line_a_oe_reg <= a_oe_next;
      line_b_oe_reg <= b_oe_next;
    end
  end

  assign serial_irq_line_a = line_a_reg;
  assign serial_irq_line_b = line_b_reg;
  assign serial_irq_line_a_oe = line_a_oe_reg;
  assign serial_irq_line_b_oe = line_b_oe_reg;

  always_comb begin
    rdata_next = SPIRQ_RD_UNMAPPED;
    unique case (avs_address)
      SPIRQ_OFF_IER0: rdata_next[SPIRQ_IER_W-1:0] = irq_source_enable_reg[0];
      SPIRQ_OFF_IER1: rdata_next[SPIRQ_IER_W-1:0] = irq_source_enable_reg[1];
      SPIRQ_OFF_MCR0: rdata_next[SPIRQ_MCR_W_ALL-1:0] = {slot_reg[0], mcr_reg[0]};
      SPIRQ_OFF_MCR1: rdata_next[SPIRQ_MCR_W_ALL-1:0] = {slot_reg[1], mcr_reg[1]};
      default: rdata_next = SPIRQ_RD_UNMAPPED;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (avs_read && !ack_reg) begin
      avs_readdata <= rdata_next;
    end
  end
endmodule : spirq_top
`default_nettype wire

// ==== tb/spirq_top_sva.sv ====
/* spirq_top_sva: port-level checks of the serial irq router.
   assumes a bind onto spirq_top, one clock, sync reset. */
`default_nettype none
module spirq_top_sva (
  input wire logic mclk,
  input wire logic reset,
  input wire logic [3:0] avs_address,
  input wire logic avs_read, avs_write, avs_waitrequest,
  input wire logic [31:0] avs_readdata,
  input wire logic [1:0] src_rx_error, src_rx_data, src_thr_empty, src_modem_change,
  input wire logic serial_irq_line_a, serial_irq_line_a_oe,
  input wire logic serial_irq_line_b, serial_irq_line_b_oe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  wire logic any_src = |{src_rx_error, src_rx_data, src_thr_empty, src_modem_change};
  sequence s_req; (avs_read || avs_write) && avs_waitrequest; endsequence
  sequence s_wdone; avs_write && !avs_waitrequest; endsequence
  a_one_wait: assert property (s_req |=> !avs_waitrequest) else $error("stall");
  a_unmapped_zero: assert property (avs_read && !avs_waitrequest && avs_address[1:0] != 2'h0
    |-> avs_readdata == 32'h0) else $error("unmapped read");
  a_reset_quiet: assert property ($past(reset) |-> !serial_irq_line_a && !serial_irq_line_b
    && !serial_irq_line_a_oe && !serial_irq_line_b_oe) else $error("reset");
  a_line_a_driven: assert property (serial_irq_line_a |-> serial_irq_line_a_oe) else $error("a");
  a_line_b_driven: assert property (serial_irq_line_b |-> serial_irq_line_b_oe) else $error("b");
  a_idle_low: assert property (!any_src |=> !serial_irq_line_a && !serial_irq_line_b)
    else $error("idle");
  a_high_pending: assert property (serial_irq_line_a || serial_irq_line_b |-> $past(any_src))
    else $error("pending");
  a_oe_by_write: assert property ($changed({serial_irq_line_a_oe, serial_irq_line_b_oe})
    && !$past(reset) |-> $past(avs_write && !avs_waitrequest, 2)) else $error("oe");
endmodule : spirq_top_sva
bind spirq_top spirq_top_sva i_sva (.mclk, .reset, .avs_address, .avs_read, .avs_write,
  .avs_waitrequest, .avs_readdata, .src_rx_error, .src_rx_data, .src_thr_empty,
  .src_modem_change, .serial_irq_line_a, .serial_irq_line_a_oe, .serial_irq_line_b,
  .serial_irq_line_b_oe);
`default_nettype wire

// ==== tb/spirq_host_pic.sv ====
/* spirq_host_pic: one interrupt input of the host controller.
   assumes a line and its output enable from spirq_top. */
`default_nettype none
module spirq_host_pic (
  input wire logic mclk,
  input wire logic line,
  input wire logic oe,
  output logic level
);
  timeunit 1ns;
  timeprecision 1ns;
  logic last_reg = 1'h0;
  always @(posedge mclk) if (oe) last_reg <= line;
  // floating line must never pass for a held level
  assign level = oe ? line : ~last_reg;
endmodule : spirq_host_pic
`default_nettype wire

// ==== tb/tb_spirq_top.sv ====
/* tb_spirq_top: random and corner runs of the serial irq router.
   assumes spirq_pkg, the checker bind and the host model are compiled first. */
`default_nettype none
module tb_spirq_top
  import spirq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [3:0] avs_address = 4'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata, q;
  logic avs_waitrequest, la, lao, lb, lbo, lev_a, lev_b, g;
  logic [1:0] s_err = 2'h0, s_dat = 2'h0, s_thr = 2'h0, s_mod = 2'h0, sl;
  logic [3:0] ie, s, s1;
  int bad_count = 0;
  int total_checks = 0;
  always #25 mclk = ~mclk;
  spirq_top i_dut (.mclk, .reset, .avs_address, .avs_read, .avs_write, .avs_writedata,
    .avs_byteenable(4'hF), .avs_readdata, .avs_waitrequest, .src_rx_error(s_err),
    .src_rx_data(s_dat), .src_thr_empty(s_thr), .src_modem_change(s_mod),
    .serial_irq_line_a(la), .serial_irq_line_a_oe(lao), .serial_irq_line_b(lb),
    .serial_irq_line_b_oe(lbo));
  spirq_host_pic i_pic_a (.mclk, .line(la), .oe(lao), .level(lev_a));
  spirq_host_pic i_pic_b (.mclk, .line(lb), .oe(lbo), .level(lev_b));
  task print_verdict;
    $display("checks %0d bad %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask : print_verdict
  task chk(input logic [31:0] got, exp);
    total_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk
  // waitrequest and read data sampled at the rising edge that completes the access
  task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d,
    output logic [31:0] r);
    int n;
    logic wt;
    n = 0;
    @(posedge mclk);
    avs_address <= a;
    avs_write <= w;
    avs_read <= !w;
    avs_writedata <= d;
    do begin
      @(posedge mclk);
      wt = avs_waitrequest;
      r = avs_readdata;
      n++;
    end while (wt !== 1'h0 && n < 16);
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    if (wt !== 1'h0) begin
      bad_count++;
      print_verdict();
    end
  endtask : bus
  function automatic logic [3:0] exp_lines(logic [1:0] sl, logic g, logic [3:0] ie, s);
    logic hit;
    hit = g & |(ie & s);
    return sl[0] ? {hit, g, 2'h0} : {2'h0, hit, g};
  endfunction : exp_lines
  task automatic step(input logic [1:0] sl, input logic g, input logic [3:0] ie, s, s1);
    bus(1'h1, SPIRQ_OFF_MCR0, {22'h0, sl, 4'h0, g, 3'h0}, q);
    bus(1'h1, SPIRQ_OFF_IER0, {28'h0, ie}, q);
    {s_dat, s_thr, s_err, s_mod} <= {s1[0], s[0], s1[1], s[1], s1[2], s[2], s1[3], s[3]};
    repeat (2) @(posedge mclk);
    @(negedge mclk);
    chk({la, lao, lb, lbo}, exp_lines(sl, g, ie, s));
    if (lao) chk(lev_a, la);
    if (lbo) chk(lev_b, lb);
  endtask : step
  initial begin
    void'($urandom(32'h66C5B41D));
    repeat (4) @(posedge mclk);
    reset <= 1'h0;
    bus(1'h0, SPIRQ_OFF_MCR1, 32'h0, q);
    chk(q, {22'h0, SPIRQ_SLOT_RST1, 8'h0});
    bus(1'h0, 4'h2, 32'h0, q);
    chk(q, SPIRQ_RD_UNMAPPED);
    // port 1 sources enabled, its gate never set
    bus(1'h1, SPIRQ_OFF_IER1, 32'hF, q);
    bus(1'h0, SPIRQ_OFF_IER1, 32'h0, q);
    chk(q, 32'hF);
    for (int i = 0; i < 40; i++) begin
      {sl, g, ie, s, s1} = 15'($urandom);
      if (i < 4) {sl, g, ie, s} = {2'(i), 1'h1, 4'hF, 4'h1 << i};
      step(sl, g, ie, s, s1);
    end
    for (int k = 0; k <= 4; k++) step(2'h1, 1'h1, 4'hF, 4'hF << k, 4'h0);
    step(2'h0, 1'h1, 4'h0, 4'hF, 4'h0);
    step(2'h0, 1'h1, 4'hF, 4'hF, 4'h0);
    @(posedge mclk) reset <= 1'h1;
    @(posedge mclk) reset <= 1'h0;
    @(negedge mclk) chk({la, lao, lb, lbo}, 4'h0);
    bus(1'h0, SPIRQ_OFF_MCR0, 32'h0, q);
    chk(q, 32'h0);
    print_verdict();
  end
endmodule : tb_spirq_top
`default_nettype wire
